// File: testbench.sv
// Self-checking testbench for the UTC time formatter
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import utf_pkg::*;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic clk, rst, epoch_start, alt_week_valid, leap_insert_now;
    logic rtc_present, rtc_powered, override_valid, text_compat_select;
    logic [9:0] epoch_week10;
    logic [19:0] seconds_into_week, rtc_sow;
    logic [31:0] epoch_ns;
    logic [15:0] alt_week, rtc_week, rollover_week_override;
    logic [1:0] leap_pending;
    logic [7:0] protocol_version;
    logic [2:0] utc_variant_select, rep_utc_variant;
    logic rep_valid, busy, local_valid, sec_bad;
    logic [11:0] rep_year;
    logic [3:0] rep_month;
    logic [4:0] rep_day, rep_hour;
    logic [5:0] rep_min, rep_sec;
    logic signed [31:0] rep_nano;
    logic [15:0] rep_full_week, local_week;
    logic [6:0] text_cs;
    logic [9:0] text_frac_ms;
    logic [1:0] text_digits;
    logic [19:0] local_sow;
    int rep_count;
    int bad_count = 0;
    int checks = 0;
    int go_count = 0;
    int exp_week;

    utf_time_formatter uut (.clk(clk), .rst(rst), .epoch_start(epoch_start),
        .epoch_week10(epoch_week10), .seconds_into_week(seconds_into_week),
        .epoch_ns(epoch_ns), .alt_week_valid(alt_week_valid),
        .alt_week(alt_week), .leap_pending(leap_pending),
        .leap_insert_now(leap_insert_now),
        .protocol_version(protocol_version), .override_valid(override_valid),
        .rollover_week_override(rollover_week_override),
        .text_compat_select(text_compat_select),
        .utc_variant_select(utc_variant_select), .rtc_present(rtc_present),
        .rtc_powered(rtc_powered), .rtc_week(rtc_week), .rtc_sow(rtc_sow),
        .rep_valid(rep_valid), .busy(busy), .rep_year(rep_year),
        .rep_month(rep_month), .rep_day(rep_day), .rep_hour(rep_hour),
        .rep_min(rep_min), .rep_sec(rep_sec), .rep_nano(rep_nano),
        .rep_full_week(rep_full_week), .rep_utc_variant(rep_utc_variant),
        .text_cs(text_cs), .text_frac_ms(text_frac_ms),
        .text_digits(text_digits), .local_valid(local_valid),
        .local_week(local_week), .local_sow(local_sow));

    utf_host_model host (.clk(clk), .rst(rst), .rep_valid(rep_valid),
        .rep_sec(rep_sec), .rep_min(rep_min),
        .protocol_version(protocol_version), .override_valid(override_valid),
        .rollover_week_override(rollover_week_override),
        .text_compat_select(text_compat_select),
        .utc_variant_select(utc_variant_select), .rep_count(rep_count),
        .sec_bad(sec_bad));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic tally_and_finish;
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, seen);
        end
    endtask

    task automatic tick;
        @(posedge clk);
        #1;
    endtask

    task automatic do_reset(input logic powered);
        rtc_powered = powered;
        rst = 1'b1;
        repeat (6) tick();
        rst = 1'b0;
        repeat (3) tick();
    endtask

    function automatic int mlen(input int m, input int y);
        case (m)
            2: return (y % 4 == 0) ? 29 : 28;
            4, 6, 9, 11: return 30;
            default: return 31;
        endcase
    endfunction

    function automatic int day_num(input int y, input int m, input int d);
        int n;
        n = 0;
        for (int i = 1980; i < y; i++) n += (i % 4 == 0) ? 366 : 365;
        for (int i = 1; i < m; i++) n += mlen(i, y);
        return n + d - 1;
    endfunction

    task automatic set_time(input int y, m, d, hh, mi, ss, ns);
        int dn;
        dn = day_num(y, m, d) - 5;
        exp_week = dn / 7;
        alt_week = exp_week[15:0];
        epoch_week10 = exp_week[9:0];
        seconds_into_week = 20'((dn % 7) * 86400 + hh * 3600 + mi * 60 + ss);
        epoch_ns = 32'(ns);
    endtask

    task automatic go;
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 600) begin
            tick();
            n++;
        end
        if (busy !== 1'b0) begin
            check("busy", 32'(busy), 0);
            tally_and_finish();
        end
        epoch_start = 1'b1;
        tick();
        epoch_start = 1'b0;
        go_count++;
        check("busy", 32'(busy), 1);
        n = 0;
        while (rep_valid !== 1'b1 && n < 600) begin
            tick();
            n++;
        end
        if (rep_valid !== 1'b1) begin
            check("rep_valid", 32'(rep_valid), 1);
            tally_and_finish();
        end
    endtask

    task automatic cmp(input int y, mo, d, h, mi, s, nano, cs);
        check("year", 32'(rep_year), y);
        check("month", 32'(rep_month), mo);
        check("day", 32'(rep_day), d);
        check("hour", 32'(rep_hour), h);
        check("min", 32'(rep_min), mi);
        check("sec", 32'(rep_sec), s);
        check("nano", rep_nano, nano);
        check("cs", 32'(text_cs), cs);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic test_rtc;
        check("local_valid", 32'(local_valid), 1);
        check("local_week", 32'(local_week), 32'h0000_0123);
        check("local_sow", 32'(local_sow), 32'h0001_2345);
    endtask

    task automatic test_round_text;
        set_time(2019, 3, 14, 12, 49, 23, 521000000);
        go();
        cmp(2019, 3, 14, 12, 49, 23, 521000000, 52);
        check("frac", 32'(text_frac_ms), 520);
        check("digits", 32'(text_digits), 2);
        check("week", 32'(rep_full_week), exp_week);
    endtask

    task automatic test_compat;
        host.write_cfg(8'h18, 1'b0, 16'h0000, 1'b1, 3'h0);
        set_time(2020, 2, 29, 6, 7, 8, 994999999);
        go();
        cmp(2020, 2, 29, 6, 7, 8, 994999999, 99);
        check("frac", 32'(text_frac_ms), 990);
        check("digits", 32'(text_digits), 3);
        host.write_cfg(8'h18, 1'b0, 16'h0000, 1'b0, 3'h0);
    endtask

    task automatic test_year_carry;
        set_time(2011, 12, 31, 23, 59, 59, 999300000);
        go();
        cmp(2012, 1, 1, 0, 0, 0, -700000, 0);
    endtask

    task automatic test_leap_insert;
        leap_pending = 2'b01;
        leap_insert_now = 1'b1;
        set_time(2016, 12, 31, 23, 59, 59, 250000000);
        go();
        cmp(2016, 12, 31, 23, 59, 60, 250000000, 25);
        leap_insert_now = 1'b0;
        leap_pending = 2'b00;
    endtask

    task automatic test_leap_delete;
        leap_pending = 2'b10;
        set_time(2015, 6, 30, 23, 59, 58, 0);
        go();
        cmp(2015, 6, 30, 23, 59, 58, 0, 0);
        set_time(2015, 6, 30, 23, 59, 59, 0);
        go();
        cmp(2015, 7, 1, 0, 0, 0, 0, 0);
        leap_pending = 2'b00;
    endtask

    task automatic test_week_legacy;
        int w10[6] = '{500, 1023, 499, 0, 5, 7};
        int ov[6] = '{1, 1, 1, 1, 0, 0};
        int pv[6] = '{23, 23, 24, 24, 23, 24};
        int ex[6] = '{1524, 2047, 2547, 2048, 2053, 2055};
        alt_week = 16'h0100;
        for (int i = 0; i < 6; i++) begin
            alt_week_valid = (i != 5) && (pv[i] == 23);
            host.write_cfg(8'(pv[i]), ov[i][0], 16'h05F4, 1'b0, 3'h0);
            epoch_week10 = 10'(w10[i]);
            go();
            check("week", 32'(rep_full_week), ex[i]);
        end
        alt_week_valid = 1'b1;
        host.write_cfg(8'h18, 1'b0, 16'h0000, 1'b0, 3'h0);
    endtask

    task automatic test_variant;
        set_time(2021, 7, 4, 1, 2, 3, 0);
        for (int v = 0; v < 8; v++) begin
            host.write_cfg(8'h18, 1'b0, 16'h0000, 1'b0, 3'(v));
            go();
            check("variant", 32'(rep_utc_variant), v);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        rst = 1'b1;
        epoch_start = 1'b0;
        alt_week_valid = 1'b1;
        leap_insert_now = 1'b0;
        leap_pending = 2'b00;
        epoch_week10 = 10'h000;
        seconds_into_week = 20'h0_0000;
        epoch_ns = 32'h0000_0000;
        alt_week = 16'h0000;
        rtc_present = 1'b1;
        rtc_powered = 1'b1;
        rtc_week = 16'h0123;
        rtc_sow = 20'h1_2345;
        do_reset(1'b1);
        test_rtc();
        test_round_text();
        test_compat();
        test_year_carry();
        test_leap_insert();
        test_leap_delete();
        test_week_legacy();
        test_variant();
        tick();
        check("sec_bad", 32'(sec_bad), 0);
        check("rep_count", rep_count, go_count);
        do_reset(1'b0);
        check("local_valid", 32'(local_valid), 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: utf_date_calc.sv
// Day count since the base year to calendar year, month and day
`timescale 1ns/100ps
`default_nettype none
module utf_date_calc
    import utf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Request
    input wire logic start,
    input wire logic [19:0] days,
    // Result
    output logic done,
    output logic [11:0] year,
    output logic [3:0] month,
    output logic [4:0] day
);
    import utf_pkg::*;

    typedef struct packed {
        utf_dstate_e state;
        logic [19:0] rem;
        logic [11:0] year;
        logic [3:0] month;
        logic [4:0] day;
        logic done;
    } utf_date_s;

    utf_date_s st_q, st_d;

    // Leap year by four-year rule, exact for 1901 to 2099
    function automatic logic is_leap(input logic [11:0] y);
        is_leap = (y[1:0] == 2'b00);
    endfunction

    function automatic logic [19:0] month_len(input logic [3:0] m,
                                              input logic [11:0] y);
        unique case (m)
            4'h2: month_len = is_leap(y) ? 20'h0_001D : 20'h0_001C;
            4'h4, 4'h6, 4'h9, 4'hB: month_len = 20'h0_001E;
            default: month_len = 20'h0_001F;
        endcase
    endfunction

    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        unique case (st_q.state)
            UTF_DS_IDLE: begin
                if (start) begin
                    st_d.rem = days;
                    st_d.year = UTF_BASE_YEAR;
                    st_d.month = 4'h1;
                    st_d.state = UTF_DS_YEAR;
                end
            end
            UTF_DS_YEAR: begin
                if (st_q.rem >= (is_leap(st_q.year) ? 20'h0_016E
                                                    : 20'h0_016D)) begin
                    st_d.rem = st_q.rem - (is_leap(st_q.year) ? 20'h0_016E
                                                              : 20'h0_016D);
                    st_d.year = st_q.year + 12'h001;
                end else begin
                    st_d.state = UTF_DS_MONTH;
                end
            end
            UTF_DS_MONTH: begin
                if (st_q.rem >= month_len(st_q.month, st_q.year)) begin
                    st_d.rem = st_q.rem - month_len(st_q.month, st_q.year);
                    st_d.month = st_q.month + 4'h1;
                end else begin
                    st_d.day = 5'(st_q.rem) + 5'h01;
                    st_d.done = 1'b1;
                    st_d.state = UTF_DS_IDLE;
                end
            end
            default: st_d.state = UTF_DS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign done = st_q.done;
    assign year = st_q.year;
    assign month = st_q.month;
    assign day = st_q.day;

    chk_date_fields: assert property (@(posedge clk) disable iff (rst)
        done |-> (month >= 4'h1 && month <= 4'hC && day >= 5'h01))
        else $error("date fields out of range");

endmodule
`default_nettype wire

// File: utf_host_model.sv
// Host model: configuration source and consumer of time reports
`timescale 1ns/100ps
`default_nettype none
module utf_host_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Report side
    input wire logic rep_valid,
    input wire logic [5:0] rep_sec,
    input wire logic [5:0] rep_min,
    // Configuration
    output logic [7:0] protocol_version,
    output logic override_valid,
    output logic [15:0] rollover_week_override,
    output logic text_compat_select,
    output logic [2:0] utc_variant_select,
    // Status
    output var int rep_count,
    output logic sec_bad
);
    // ------------------------------------------------------------------
    // Configuration writes
    // ------------------------------------------------------------------
    initial begin
        protocol_version = 8'h18;
        override_valid = 1'b0;
        rollover_week_override = 16'h0000;
        text_compat_select = 1'b0;
        utc_variant_select = 3'h0;
    end

    task automatic write_cfg(input logic [7:0] pv, input logic ov,
                             input logic [15:0] rw, input logic tc,
                             input logic [2:0] uv);
        protocol_version = pv;
        override_valid = ov;
        rollover_week_override = rw;
        text_compat_select = tc;
        utc_variant_select = uv;
    endtask

    // ------------------------------------------------------------------
    // Report intake: minutes of 59 or 61 seconds are accepted
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            rep_count <= 0;
            sec_bad <= 1'b0;
        end else if (rep_valid) begin
            rep_count <= rep_count + 1;
            if (rep_sec > 6'h3C || rep_min > 6'h3B) begin
                sec_bad <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: utf_pkg.sv
// Shared constants and types for the UTC time formatter
package utf_pkg;

    // ------------------------------------------------------------------
    // Time constants
    // ------------------------------------------------------------------
    localparam logic [31:0] UTF_NS_PER_S = 32'h3B9A_CA00;
    localparam logic [31:0] UTF_NS_HALF_CS = 32'h004C_4B40;
    localparam logic [31:0] UTF_NS_PER_CS = 32'h0098_9680;
    localparam logic [31:0] UTF_NS_ROUND_UP = 32'h3B4E_7EC0;
    localparam logic [16:0] UTF_S_PER_DAY = 17'h1_5180;
    localparam logic [16:0] UTF_S_LAST_OF_DAY = 17'h1_517F;
    localparam logic [16:0] UTF_S_PER_HOUR = 17'h0_0E10;
    localparam logic [16:0] UTF_S_PER_MIN = 17'h0_003C;

    // ------------------------------------------------------------------
    // Week and date constants
    // ------------------------------------------------------------------
    localparam logic [15:0] UTF_WEEK_WRAP = 16'h0400;
    localparam logic [15:0] UTF_DEF_REF_WEEK = 16'h0800;
    localparam logic [7:0] UTF_MIN_PROTO_ALT = 8'h18;
    localparam logic [19:0] UTF_EPOCH_DAY_OFS = 20'h0_0005;
    localparam logic [11:0] UTF_BASE_YEAR = 12'h07BC;
    localparam logic [6:0] UTF_CS_PER_S = 7'h64;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        UTF_LEAP_NONE = 2'b00,
        UTF_LEAP_INS = 2'b01,
        UTF_LEAP_DEL = 2'b10
    } utf_leap_e;

    typedef enum logic [2:0] {
        UTF_ST_INIT = 3'b000,
        UTF_ST_IDLE = 3'b001,
        UTF_ST_CS = 3'b010,
        UTF_ST_DAYS = 3'b011,
        UTF_ST_FIX = 3'b100,
        UTF_ST_HMS = 3'b101,
        UTF_ST_DATE = 3'b110
    } utf_state_e;

    typedef enum logic [1:0] {
        UTF_DS_IDLE = 2'b00,
        UTF_DS_YEAR = 2'b01,
        UTF_DS_MONTH = 2'b10
    } utf_dstate_e;

endpackage

// File: utf_time_formatter.sv
// UTC time formatter: rounding, calendar split, leap seconds, week
`timescale 1ns/100ps
`default_nettype none
module utf_time_formatter
    import utf_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Epoch input
    input wire logic epoch_start,
    input wire logic [9:0] epoch_week10,
    input wire logic [19:0] seconds_into_week,
    input wire logic [31:0] epoch_ns,
    input wire logic alt_week_valid,
    input wire logic [15:0] alt_week,
    input wire logic [1:0] leap_pending,
    input wire logic leap_insert_now,
    // Configuration
    input wire logic [7:0] protocol_version,
    input wire logic override_valid,
    input wire logic [15:0] rollover_week_override,
    input wire logic text_compat_select,
    input wire logic [2:0] utc_variant_select,
    // Backed real-time clock
    input wire logic rtc_present,
    input wire logic rtc_powered,
    input wire logic [15:0] rtc_week,
    input wire logic [19:0] rtc_sow,
    // Report output
    output logic rep_valid,
    output logic busy,
    output logic [11:0] rep_year,
    output logic [3:0] rep_month,
    output logic [4:0] rep_day,
    output logic [4:0] rep_hour,
    output logic [5:0] rep_min,
    output logic [5:0] rep_sec,
    output logic signed [31:0] rep_nano,
    output logic [15:0] rep_full_week,
    output logic [2:0] rep_utc_variant,
    // Text output
    output logic [6:0] text_cs,
    output logic [9:0] text_frac_ms,
    output logic [1:0] text_digits,
    // Local time
    output logic local_valid,
    output logic [15:0] local_week,
    output logic [19:0] local_sow
);
    import utf_pkg::*;

    typedef struct packed {
        utf_state_e state;
        utf_leap_e leap;
        logic ins;
        logic carry;
        logic use_alt;
        logic compat;
        logic [15:0] ref_week;
        logic [9:0] week10;
        logic [15:0] week;
        logic [31:0] rem;
        logic [6:0] cs;
        logic [19:0] days;
        logic [16:0] tod;
        logic [19:0] sow;
        logic [4:0] hour;
        logic [5:0] min;
        logic [5:0] sec;
        logic signed [31:0] nano;
        logic [2:0] variant;
        logic date_go;
        logic rep_valid;
        logic busy;
        logic [11:0] r_year;
        logic [3:0] r_month;
        logic [4:0] r_day;
        logic [4:0] r_hour;
        logic [5:0] r_min;
        logic [5:0] r_sec;
        logic signed [31:0] r_nano;
        logic [15:0] r_week;
        logic [2:0] r_variant;
        logic [6:0] r_cs;
        logic [9:0] r_frac_ms;
        logic [1:0] r_digits;
        logic loc_valid;
        logic [15:0] loc_week;
        logic [19:0] loc_sow;
    } utf_state_s;

    utf_state_s st_q, st_d;
    logic date_done;
    logic [11:0] date_year;
    logic [3:0] date_month;
    logic [4:0] date_day;
    logic [15:0] ref_w;
    logic [15:0] exp_w;

    utf_date_calc u_date (
        .clk(clk),
        .rst(rst),
        .start(st_q.date_go),
        .days(st_q.days),
        .done(date_done),
        .year(date_year),
        .month(date_month),
        .day(date_day)
    );

    // ------------------------------------------------------------------
    // Week resolution
    // ------------------------------------------------------------------
    always_comb begin
        ref_w = override_valid ? rollover_week_override : UTF_DEF_REF_WEEK;
        exp_w = {ref_w[15:10], epoch_week10};
        if (epoch_week10 < ref_w[9:0]) begin
            exp_w = exp_w + UTF_WEEK_WRAP;
        end
    end

    // ------------------------------------------------------------------
    // Conversion sequence
    // ------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        st_d.date_go = 1'b0;
        st_d.rep_valid = 1'b0;
        unique case (st_q.state)
            UTF_ST_INIT: begin
                if (rtc_present && rtc_powered) begin
                    st_d.loc_valid = 1'b1;
                    st_d.loc_week = rtc_week;
                    st_d.loc_sow = rtc_sow;
                end
                st_d.state = UTF_ST_IDLE;
            end
            UTF_ST_IDLE: begin
                if (epoch_start) begin
                    st_d.use_alt = alt_week_valid &&
                        (protocol_version >= UTF_MIN_PROTO_ALT);
                    st_d.week = st_d.use_alt ? alt_week : exp_w;
                    st_d.week10 = epoch_week10;
                    st_d.ref_week = ref_w;
                    st_d.carry = (epoch_ns >= UTF_NS_ROUND_UP);
                    st_d.nano = st_d.carry ? $signed(epoch_ns - UTF_NS_PER_S)
                                           : $signed(epoch_ns);
                    st_d.rem = epoch_ns + UTF_NS_HALF_CS;
                    st_d.cs = 7'h00;
                    st_d.days = 20'(({4'h0, st_d.week} << 3) -
                        {4'h0, st_d.week}) + UTF_EPOCH_DAY_OFS;
                    st_d.sow = seconds_into_week;
                    st_d.leap = utf_leap_e'(leap_pending);
                    st_d.ins = leap_insert_now;
                    st_d.compat = text_compat_select;
                    st_d.variant = utc_variant_select;
                    st_d.hour = 5'h00;
                    st_d.min = 6'h00;
                    st_d.state = UTF_ST_CS;
                end
            end
            UTF_ST_CS: begin
                if (!st_q.carry && st_q.rem >= UTF_NS_PER_CS) begin
                    st_d.rem = st_q.rem - UTF_NS_PER_CS;
                    st_d.cs = st_q.cs + 7'h01;
                end else begin
                    st_d.state = UTF_ST_DAYS;
                end
            end
            UTF_ST_DAYS: begin
                if (st_q.sow >= {3'b000, UTF_S_PER_DAY}) begin
                    st_d.sow = st_q.sow - {3'b000, UTF_S_PER_DAY};
                    st_d.days = st_q.days + 20'h0_0001;
                end else begin
                    st_d.tod = 17'(st_q.sow);
                    st_d.state = UTF_ST_FIX;
                end
            end
            UTF_ST_FIX: begin
                st_d.tod = st_q.tod + {16'h0000, st_q.carry};
                if (st_q.carry) begin
                    st_d.ins = 1'b0;
                end
                if (st_q.leap == UTF_LEAP_DEL && !st_q.ins &&
                    st_d.tod == UTF_S_LAST_OF_DAY) begin
                    st_d.tod = UTF_S_PER_DAY;
                end
                if (st_d.tod == UTF_S_PER_DAY) begin
                    st_d.tod = 17'h0_0000;
                    st_d.days = st_q.days + 20'h0_0001;
                end
                st_d.state = UTF_ST_HMS;
            end
            UTF_ST_HMS: begin
                if (st_q.tod >= UTF_S_PER_HOUR) begin
                    st_d.tod = st_q.tod - UTF_S_PER_HOUR;
                    st_d.hour = st_q.hour + 5'h01;
                end else if (st_q.tod >= UTF_S_PER_MIN) begin
                    st_d.tod = st_q.tod - UTF_S_PER_MIN;
                    st_d.min = st_q.min + 6'h01;
                end else begin
                    st_d.sec = 6'(st_q.tod) + {5'h00, st_q.ins};
                    st_d.date_go = 1'b1;
                    st_d.state = UTF_ST_DATE;
                end
            end
            UTF_ST_DATE: begin
                if (date_done) begin
                    st_d.rep_valid = 1'b1;
                    st_d.r_year = date_year;
                    st_d.r_month = date_month;
                    st_d.r_day = date_day;
                    st_d.r_hour = st_q.hour;
                    st_d.r_min = st_q.min;
                    st_d.r_sec = st_q.sec;
                    st_d.r_nano = st_q.nano;
                    st_d.r_week = st_q.week;
                    st_d.r_variant = st_q.variant;
                    st_d.r_cs = (st_q.cs == UTF_CS_PER_S) ? 7'h00 : st_q.cs;
                    st_d.r_frac_ms = 10'(st_d.r_cs * 10'h00A);
                    st_d.r_digits = st_q.compat ? 2'h3 : 2'h2;
                    st_d.state = UTF_ST_IDLE;
                end
            end
            default: st_d.state = UTF_ST_IDLE;
        endcase
        st_d.busy = (st_d.state != UTF_ST_IDLE);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign rep_valid = st_q.rep_valid;
    assign busy = st_q.busy;
    assign rep_year = st_q.r_year;
    assign rep_month = st_q.r_month;
    assign rep_day = st_q.r_day;
    assign rep_hour = st_q.r_hour;
    assign rep_min = st_q.r_min;
    assign rep_sec = st_q.r_sec;
    assign rep_nano = st_q.r_nano;
    assign rep_full_week = st_q.r_week;
    assign rep_utc_variant = st_q.r_variant;
    assign text_cs = st_q.r_cs;
    assign text_frac_ms = st_q.r_frac_ms;
    assign text_digits = st_q.r_digits;
    assign local_valid = st_q.loc_valid;
    assign local_week = st_q.loc_week;
    assign local_sow = st_q.loc_sow;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence s_epoch_taken;
        epoch_start && st_q.state == UTF_ST_IDLE;
    endsequence

    sequence s_report;
        ##[4:600] rep_valid;
    endsequence

    chk_report_time: assert property (@(posedge clk) disable iff (rst)
        s_epoch_taken |-> s_report)
        else $error("report not produced in time");

    chk_nano_range: assert property (@(posedge clk) disable iff (rst)
        rep_valid |-> (rep_nano >= -32'sd5000000 &&
                       rep_nano <= 32'sd994999999))
        else $error("nano correction out of range");

    chk_carry_zero: assert property (@(posedge clk) disable iff (rst)
        rep_valid && rep_nano < 0 |-> text_cs == 7'h00)
        else $error("negative nano without round up");

    chk_third_zero: assert property (@(posedge clk) disable iff (rst)
        rep_valid |-> text_frac_ms == 10'(text_cs * 10'h00A) &&
            text_cs < UTF_CS_PER_S)
        else $error("third fraction digit not zero");

    chk_leap_sixty: assert property (@(posedge clk) disable iff (rst)
        rep_valid && rep_sec == 6'h3C |-> rep_hour == 5'h17 &&
            rep_min == 6'h3B && $past(st_q.ins))
        else $error("second 60 outside inserted leap second");

    chk_leap_skip: assert property (@(posedge clk) disable iff (rst)
        rep_valid && $past(st_q.leap) == UTF_LEAP_DEL && !$past(st_q.ins)
        |-> !(rep_hour == 5'h17 && rep_min == 6'h3B && rep_sec == 6'h3B))
        else $error("deleted second was shown");

    chk_week_expand: assert property (@(posedge clk)
        disable iff (rst) rep_valid && !$past(st_q.use_alt) |->
            rep_full_week[9:0] == $past(st_q.week10) &&
            rep_full_week >= $past(st_q.ref_week) &&
            rep_full_week < $past(st_q.ref_week) + UTF_WEEK_WRAP)
        else $error("wrapped week badly expanded");

    chk_rtc_load: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) && rtc_present && rtc_powered |-> ##1 local_valid)
        else $error("local time not loaded from clock");

endmodule
`default_nettype wire
